/* File: design/trs_pkg.sv */
// Package for the trigger route switch: register map, fields and route codes
package trs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and trigger line count
  // ----------------------------------------------------------------
  localparam int unsigned TRS_ADDR_W    = 8;
  localparam int unsigned TRS_DATA_W    = 32;
  localparam int unsigned TRS_NUM_LINES = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TRS_OFF_ROUTE  = 8'h00;
  localparam logic [7:0] TRS_OFF_CMD    = 8'h04;
  localparam logic [7:0] TRS_OFF_SWLVL  = 8'h08;
  localparam logic [7:0] TRS_OFF_STATUS = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TRS_ROUTE_KIND_LSB = 0;
  localparam int unsigned TRS_ROUTE_MASK_LSB = 8;
  localparam int unsigned TRS_CMD_CLEAR_BIT  = 0;
  localparam int unsigned TRS_CMD_FULL_BIT   = 1;
  localparam int unsigned TRS_SWLVL_BIT      = 0;
  localparam int unsigned TRS_STAT_ACT_BIT   = 0;
  localparam int unsigned TRS_STAT_ERR_BIT   = 1;

  // ----------------------------------------------------------------
  // Route codes and route configuration
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    route_code_none    = 3'b000,
    route_smb_to_bus   = 3'b001,
    route_bus_to_smb   = 3'b010,
    route_sw_to_bus    = 3'b011,
    route_sw_bus_smb   = 3'b100,
    route_bus_to_bus   = 3'b101,
    route_smb_loopback = 3'b110
  } trs_route_t;

  typedef struct packed {
    trs_route_t  kind;
    logic [7:0]  line_mask;
  } trs_route_cfg_t;

  // ----------------------------------------------------------------
  // Reset values and bus responses
  // ----------------------------------------------------------------
  localparam trs_route_cfg_t TRS_ROUTE_RST = '{kind: route_code_none, line_mask: 8'h00};
  localparam logic           TRS_SWLVL_RST = 1'b1;
  localparam logic [1:0]     TRS_RESP_OKAY = 2'h0;
  localparam logic [1:0]     TRS_RESP_SLV  = 2'h2;

endpackage : trs_pkg

/* File: design/trs_route_mux.sv */
// Routing fabric: steers SMB, backplane lines and software level
`timescale 1ns/1ps
module trs_route_mux
  import trs_pkg::*;
(
  input  wire logic           sys_clk_i,
  input  wire logic           reset_n_i,
  input  wire trs_route_cfg_t cfg_i,
  input  wire logic           sw_level_i,
  input  wire logic           smb_in_i,
  input  wire logic [7:0]     trig_in_i,
  output logic                smb_out_o,
  output logic                smb_oe_o,
  output logic [7:0]          trig_out_o,
  output logic [7:0]          trig_oe_o
);

  logic       smb_out_nxt;
  logic       smb_oe_nxt;
  logic [7:0] trig_out_nxt;
  logic [7:0] trig_oe_nxt;

  // ----------------------------------------------------------------
  // Path selection
  // ----------------------------------------------------------------
  // levels pass unchanged
  // Every path copies the level, so edges reach receivers one cycle late
  always_comb begin
    smb_out_nxt  = 1'b0;
    smb_oe_nxt   = 1'b0;
    trig_out_nxt = 8'h00;
    trig_oe_nxt  = 8'h00;
    unique case (cfg_i.kind)
      route_smb_to_bus: begin
        trig_oe_nxt  = cfg_i.line_mask;
        trig_out_nxt = {8{smb_in_i}} & cfg_i.line_mask;
      end
      route_bus_to_smb: begin
        smb_oe_nxt  = 1'b1;
        smb_out_nxt = |(trig_in_i & cfg_i.line_mask);
      end
      route_sw_to_bus: begin
        trig_oe_nxt  = cfg_i.line_mask;
        trig_out_nxt = {8{sw_level_i}} & cfg_i.line_mask;
      end
      route_sw_bus_smb: begin
        trig_oe_nxt  = cfg_i.line_mask;
        trig_out_nxt = {8{sw_level_i}} & cfg_i.line_mask;
        smb_oe_nxt   = 1'b1;
        smb_out_nxt  = |trig_out_nxt;
      end
      default: begin
        smb_oe_nxt  = 1'b0;
        trig_oe_nxt = 8'h00;
      end
    endcase
  end

  // Registered pins keep glitches of the decode off the backplane
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smb_out_o  <= 1'b0;
      smb_oe_o   <= 1'b0;
      trig_out_o <= 8'h00;
      trig_oe_o  <= 8'h00;
    end else begin
      smb_out_o  <= smb_out_nxt;
      smb_oe_o   <= smb_oe_nxt;
      trig_out_o <= trig_out_nxt;
      trig_oe_o  <= trig_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Each route is checked one cycle after the route and inputs it copies
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  smb_to_bus_a: assert property ($past(cfg_i.kind) == route_smb_to_bus |->
    trig_oe_o == $past(cfg_i.line_mask) &&
    trig_out_o == ({8{$past(smb_in_i)}} & $past(cfg_i.line_mask)))
    else $error("SMB not copied onto selected line");
  bus_to_smb_a: assert property ($past(cfg_i.kind) == route_bus_to_smb |->
    smb_oe_o && smb_out_o == |($past(trig_in_i) & $past(cfg_i.line_mask)))
    else $error("Selected line not copied to SMB");
  sw_to_bus_a: assert property ($past(cfg_i.kind) == route_sw_to_bus |->
    trig_out_o == ({8{$past(sw_level_i)}} & $past(cfg_i.line_mask)) && !smb_oe_o)
    else $error("Software level not on selected line");
  sw_bus_smb_a: assert property ($past(cfg_i.kind) == route_sw_bus_smb |->
    smb_oe_o && smb_out_o == $past(sw_level_i) && trig_oe_o == $past(cfg_i.line_mask))
    else $error("Software level not on line and SMB");

endmodule : trs_route_mux

/* File: design/trs_route_switch.sv */
// Trigger route switch top: AXI4-Lite registers, route checks, fabric
//
// Function
// - Route the SMB input onto one chosen backplane line.
// - Drive the SMB connector from one chosen backplane line.
// - Drive one chosen backplane line from the software level.
// - Software level drives a line, and that line drives the SMB.
// - Triggers are TTL levels; receivers act on their edges.
// - After power-on or clear, nothing is connected anywhere.
// - Route readback after power-on or clear gives the none code.
// - Any other route request errors and leaves the routing untouched.
// - Line-to-line requests are refused as invalid.
// - SMB loopback requests are refused as invalid.
// - Active status reads true only while routing is enabled.
// - Applied route type and line can be read back anytime.
// - Clear opens all paths and disables routing.
// - Software trigger is a static level: true high, false low.
// - Clear leaves the stored software level unchanged.
// - Full reset and power-on set the software level true.
`timescale 1ns/1ps
module trs_route_switch
  import trs_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Trigger pins
  input  wire logic              smb_in_i,
  output logic                   smb_out_o,
  output logic                   smb_oe_o,
  input  wire logic [7:0]        trig_in_i,
  output logic [7:0]             trig_out_o,
  output logic [7:0]             trig_oe_o,
  output logic                   routing_active_flag_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Only whole aligned words of the four registers are mapped
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == TRS_OFF_ROUTE) || (a == TRS_OFF_CMD) ||
                  (a == TRS_OFF_SWLVL) || (a == TRS_OFF_STATUS);
  endfunction : addr_mapped

  // Merge written byte lanes onto an old word
  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    strb_merge = m;
  endfunction : strb_merge

  // Four legal kinds, each with exactly one line
  function automatic logic legal_route(input trs_route_cfg_t c);
    case (c.kind)
      route_smb_to_bus, route_bus_to_smb, route_sw_to_bus, route_sw_bus_smb:
        legal_route = $onehot(c.line_mask);
      default:
        legal_route = 1'b0;
    endcase
  endfunction : legal_route

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  trs_route_cfg_t cfg_r,      cfg_nxt;
  logic           sw_level_r, sw_level_nxt;
  logic           err_r,      err_nxt;
  logic           aw_got_r,   aw_got_nxt;
  logic           w_got_r,    w_got_nxt;
  logic [7:0]     awaddr_r,   awaddr_nxt;
  logic [31:0]    wdata_r,    wdata_nxt;
  logic [3:0]     wstrb_r,    wstrb_nxt;
  logic           bvalid_r,   bvalid_nxt;
  logic [1:0]     bresp_r,    bresp_nxt;
  logic           rvalid_r,   rvalid_nxt;
  logic [31:0]    rdata_r,    rdata_nxt;
  logic [1:0]     rresp_r,    rresp_nxt;

  logic           do_write;
  logic           wr_route;
  logic           clr_cmd;
  logic           full_cmd;
  logic           wr_swlvl;
  logic           wr_stat;
  logic           route_bad;
  logic [31:0]    route_word;
  logic [31:0]    stat_word;
  logic [31:0]    wmerged;
  logic [31:0]    rd_word;
  trs_route_cfg_t req_cfg;

  // ----------------------------------------------------------------
  // Readback words and write decode
  // ----------------------------------------------------------------
  // cleared route reads none
  assign route_word = {16'h0000, cfg_r.line_mask, 5'h00, cfg_r.kind};
  // active only while a route is applied
  assign routing_active_flag_o = (cfg_r.kind != route_code_none);
  assign stat_word  = {30'h0, err_r, routing_active_flag_o};

  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign wr_route = do_write && (awaddr_r == TRS_OFF_ROUTE);
  assign wr_swlvl = do_write && (awaddr_r == TRS_OFF_SWLVL);
  assign wr_stat  = do_write && (awaddr_r == TRS_OFF_STATUS);

  // Base word for the merge: command bits are pulses and start from zero
  always_comb begin
    unique case (awaddr_r)
      TRS_OFF_ROUTE:  wmerged = strb_merge(route_word, wdata_r, wstrb_r);
      TRS_OFF_SWLVL:  wmerged = strb_merge({31'h0, sw_level_r}, wdata_r, wstrb_r);
      default:        wmerged = strb_merge(32'h0000_0000, wdata_r, wstrb_r);
    endcase
  end

  assign req_cfg  = '{kind: trs_route_t'(wmerged[TRS_ROUTE_KIND_LSB +: 3]),
                      line_mask: wmerged[TRS_ROUTE_MASK_LSB +: 8]};
  assign route_bad = wr_route && !legal_route(req_cfg);
  assign full_cmd  = do_write && (awaddr_r == TRS_OFF_CMD) && wmerged[TRS_CMD_FULL_BIT];
  assign clr_cmd   = do_write && (awaddr_r == TRS_OFF_CMD) && wmerged[TRS_CMD_CLEAR_BIT];

  // ----------------------------------------------------------------
  // Route and software level
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt      = cfg_r;
    sw_level_nxt = sw_level_r;
    err_nxt      = err_r;
    if (full_cmd) begin
      cfg_nxt      = TRS_ROUTE_RST;
      sw_level_nxt = TRS_SWLVL_RST;
      err_nxt      = 1'b0;
    end else if (clr_cmd) begin
      cfg_nxt = TRS_ROUTE_RST;
    end
    if (wr_route && !route_bad) begin
      cfg_nxt = req_cfg;
    end
    if (wr_swlvl) begin
      sw_level_nxt = wmerged[TRS_SWLVL_BIT];
    end
    // Write one to clear; a rejection in the same cycle wins
    if (wr_stat && wmerged[TRS_STAT_ERR_BIT]) begin
      err_nxt = 1'b0;
    end
    if (route_bad) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_r      <= TRS_ROUTE_RST;
      sw_level_r <= TRS_SWLVL_RST;
      err_r      <= 1'b0;
    end else begin
      cfg_r      <= cfg_nxt;
      sw_level_r <= sw_level_nxt;
      err_r      <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite channels
  // ----------------------------------------------------------------
  // One write and one read in flight; a pending response blocks new addresses
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read mux; the command register reads as zero
  always_comb begin
    unique case (s_axi_araddr)
      TRS_OFF_ROUTE:  rd_word = route_word;
      TRS_OFF_SWLVL:  rd_word = {31'h0, sw_level_r};
      TRS_OFF_STATUS: rd_word = stat_word;
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (!addr_mapped(awaddr_r) || route_bad) ? TRS_RESP_SLV : TRS_RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = addr_mapped(s_axi_araddr) ? TRS_RESP_OKAY : TRS_RESP_SLV;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= TRS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= TRS_RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Routing fabric
  // ----------------------------------------------------------------
  trs_route_mux u_mux (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .cfg_i      (cfg_r),
    .sw_level_i (sw_level_r),
    .smb_in_i   (smb_in_i),
    .trig_in_i  (trig_in_i),
    .smb_out_o  (smb_out_o),
    .smb_oe_o   (smb_oe_o),
    .trig_out_o (trig_out_o),
    .trig_oe_o  (trig_oe_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  bad_route_a: assert property (route_bad |=> $stable(cfg_r) && err_r &&
    s_axi_bvalid && s_axi_bresp == TRS_RESP_SLV)
    else $error("Invalid route altered routing or gave no error");
  clear_open_a: assert property (clr_cmd |=> !routing_active_flag_o
    ##1 (trig_oe_o == 8'h00 && !smb_oe_o))
    else $error("Clear left a path open");
  clear_keep_a: assert property (clr_cmd && !full_cmd |=>
    sw_level_r == $past(sw_level_r))
    else $error("Clear changed the software level");
  full_level_a: assert property (full_cmd |=>
    sw_level_r && cfg_r.kind == route_code_none)
    else $error("Full reset did not set level true");
  level_static_a: assert property (!wr_swlvl && !full_cmd |=> $stable(sw_level_r))
    else $error("Software level changed without a write");
  idle_hiz_a: assert property (!routing_active_flag_o ##1 !routing_active_flag_o |->
    trig_oe_o == 8'h00 && !smb_oe_o)
    else $error("Output driven while routing disabled");
  route_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == TRS_OFF_ROUTE |=> s_axi_rdata[2:0] == $past(cfg_r.kind) &&
    s_axi_rdata[15:8] == $past(cfg_r.line_mask))
    else $error("Route readback differs from applied route");
  act_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == TRS_OFF_STATUS |=> s_axi_rdata[0] == ($past(cfg_r.kind) != route_code_none))
    else $error("Active status does not match routing state");

  apply_ok_c:  cover property (wr_route && !route_bad ##1 routing_active_flag_o);
  apply_bad_c: cover property (route_bad ##1 err_r);
  clear_c:     cover property (routing_active_flag_o ##1 clr_cmd ##1 !routing_active_flag_o);
  pulse_c:     cover property (wr_swlvl ##[1:20] wr_swlvl);

endmodule : trs_route_switch

/* File: testbench/trigger_route_switch_tb.sv */
// Self-checking bench for the trigger route switch
`timescale 1ns/1ps
module trigger_route_switch_tb;
  import trs_pkg::*;
  logic sys_clk_i, reset_n_i, awv, wv, brdy, arv, rrdy, smb_en, smb_val;
  logic [7:0]  awa, ara, drv_en, drv_val, trig_in, trig_out, trig_oe, msk;
  logic [31:0] wd, rd, got, bw;
  logic [3:0]  ws;
  logic [2:0]  kd;
  logic [1:0]  br, rr, resp;
  logic        awr, wr, bv, arr, rv, smb_in, smb_out, smb_oe, act, sw;
  int          miscompares, check_count, seed, ln;
  trs_route_switch dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .smb_in_i(smb_in), .smb_out_o(smb_out), .smb_oe_o(smb_oe), .trig_in_i(trig_in),
    .trig_out_o(trig_out), .trig_oe_o(trig_oe), .routing_active_flag_o(act));
  trs_chassis_model chassis_u (.sys_clk_i(sys_clk_i), .dut_oe_i(trig_oe), .dut_out_i(trig_out),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .smb_oe_i(smb_oe), .smb_out_i(smb_out),
    .smb_en_i(smb_en), .smb_val_i(smb_val), .trig_o(trig_in), .smb_o(smb_in));
  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wait_out(input int n);
    if (n >= 100) begin
      miscompares++;
      $display("BAD t=%0t bus answer never came", $time);
      finish_test();
    end
  endtask : wait_out
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ao, wo, done;
    n = 0; ao = 0; wo = 0; done = 0;
    @(posedge sys_clk_i);
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    while (!done && n < 100) begin
      @(negedge sys_clk_i);
      ao = ao | (awv & awr);
      wo = wo | (wv & wr);
      done = (bv === 1'b1);
      resp = br;
      @(posedge sys_clk_i);
      if (ao) awv <= 1'b0;
      if (wo) wv <= 1'b0;
      if (done) brdy <= 1'b0;
      n++;
    end
    wait_out(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic done, ao;
    n = 0; done = 0; ao = 0;
    @(posedge sys_clk_i);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    while (!done && n < 100) begin
      @(negedge sys_clk_i);
      ao = ao | (arv & arr);
      done = (rv === 1'b1);
      got = rd; resp = rr;
      @(posedge sys_clk_i);
      if (ao) arv <= 1'b0;
      if (done) rrdy <= 1'b0;
      n++;
    end
    wait_out(n);
  endtask : axi_rd
  // Expected {line oe, line level, smb oe, smb level} for a route kind
  function automatic logic [3:0] exp_pins(input logic [2:0] k, input logic s, input logic i,
                                          input logic l);
    case (k)
      3'd1: return {1'b1, i, 2'b00};
      3'd2: return {2'b00, 1'b1, l};
      3'd3: return {1'b1, s, 2'b00};
      3'd4: return {1'b1, s, 1'b1, s};
      default: return 4'h0;
    endcase
  endfunction : exp_pins
  // Expectation formed after the wait, once the partner inputs have settled
  task automatic chk_pins(input logic [2:0] k, input logic s);
    logic [3:0] e;
    repeat (3) @(negedge sys_clk_i);
    e = exp_pins(k, s, smb_val, drv_val[ln]);
    chk(trig_oe, e[3] ? msk : 8'h00, "line enables");
    chk({trig_oe[ln] & trig_out[ln], smb_oe, smb_oe & smb_out}, e[2:0], "pin levels");
  endtask : chk_pins
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    miscompares = 0; check_count = 0; seed = 86312; ln = 0; msk = 8'h01;
    {awv, wv, brdy, arv, rrdy, smb_en, smb_val} = '0;
    {awa, ara, drv_en, drv_val, wd, ws} = '0;
    reset_n_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    axi_rd(TRS_OFF_ROUTE); chk(got, 32'h0, "route at reset");
    axi_rd(TRS_OFF_SWLVL); chk(got, 32'h1, "level at reset");
    axi_rd(TRS_OFF_STATUS); chk(got, 32'h0, "status at reset");
    chk_pins(3'd0, 1'b0);
    $display("test reset done");
    // each legal route with random line
    for (int t = 0; t < 8; t++) begin
      @(posedge sys_clk_i);
      kd = 3'(t % 4 + 1);
      ln = $unsigned($random(seed)) % 8;
      msk = 8'h01 << ln;
      sw = $random(seed);
      smb_en <= (kd == 3'd1); smb_val <= $random(seed);
      drv_en <= (kd == 3'd2) ? msk : 8'h00; drv_val <= 8'($random(seed));
      axi_wr(TRS_OFF_SWLVL, {31'h0, sw});
      axi_wr(TRS_OFF_ROUTE, {16'h0, msk, 5'h0, kd});
      chk(resp, TRS_RESP_OKAY, "legal route");
      axi_rd(TRS_OFF_ROUTE); chk(got, {16'h0, msk, 5'h0, kd}, "route readback");
      axi_rd(TRS_OFF_STATUS); chk(got[0], 1'b1, "active flag");
      chk(act, 1'b1, "active pin");
      for (int v = 0; v < 2; v++) begin
        chk_pins(kd, sw);
        sw = ~sw;
        axi_wr(TRS_OFF_SWLVL, {31'h0, sw});
        smb_val <= ~smb_val; drv_val <= ~drv_val;
      end
      $display("test route kind %0d line %0d done", kd, ln);
    end
    for (int t = 0; t < 6; t++) begin
      bw = (t < 4) ? {16'h0, msk, 5'h0, 3'(t + 5)} : {16'h0, (t == 4) ? 8'h00 : 8'h81, 8'h01};
      axi_wr(TRS_OFF_ROUTE, bw); chk(resp, TRS_RESP_SLV, "bad route refused");
      axi_rd(TRS_OFF_ROUTE); chk(got, {16'h0, msk, 5'h0, kd}, "route kept");
      axi_rd(TRS_OFF_STATUS); chk(got[1:0], 2'b11, "error flag");
      axi_wr(TRS_OFF_STATUS, 32'h2);
      axi_rd(TRS_OFF_STATUS); chk(got[1:0], 2'b01, "error cleared");
    end
    $display("test refusals done");
    axi_wr(TRS_OFF_SWLVL, 32'h0);
    axi_wr(TRS_OFF_CMD, 32'h1);
    axi_rd(TRS_OFF_ROUTE); chk(got, 32'h0, "route after clear");
    axi_rd(TRS_OFF_STATUS); chk(got, 32'h0, "inactive after clear");
    axi_rd(TRS_OFF_SWLVL); chk(got, 32'h0, "level kept");
    drv_en <= 8'h00; smb_en <= 1'b0;
    chk_pins(3'd0, 1'b0);
    axi_rd(TRS_OFF_CMD); chk(got, 32'h0, "command reads zero");
    axi_wr(TRS_OFF_CMD, 32'h2);
    axi_rd(TRS_OFF_SWLVL); chk(got, 32'h1, "level after full reset");
    axi_rd(8'h10); chk(resp, TRS_RESP_SLV, "unmapped read");
    axi_wr(8'h20, 32'h1); chk(resp, TRS_RESP_SLV, "unmapped write");
    $display("test clear and reset done");
    finish_test();
  end
endmodule : trigger_route_switch_tb

/* File: testbench/trs_chassis_model.sv */
// Chassis partner model: other modules on the backplane lines and the SMB source
`timescale 1ns/1ps
module trs_chassis_model
  import trs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] dut_oe_i,
  input  wire logic [7:0] dut_out_i,
  input  wire logic [7:0] drv_en_i,
  input  wire logic [7:0] drv_val_i,
  input  wire logic       smb_oe_i,
  input  wire logic       smb_out_i,
  input  wire logic       smb_en_i,
  input  wire logic       smb_val_i,
  output logic [7:0]      trig_o,
  output logic            smb_o
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [7:0] idle_r = 8'h5A;
  // Released lines change every cycle so a stale level never passes
  always @(posedge sys_clk_i) idle_r <= ~idle_r;
  assign trig_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & drv_en_i & drv_val_i)
                | (~dut_oe_i & ~drv_en_i & idle_r);
  // SMB has a weak pull-down when nobody drives it
  assign smb_o = smb_oe_i ? smb_out_i : (smb_en_i & smb_val_i);
endmodule : trs_chassis_model
